/* File: logic/dbg_cmp_pkg.sv */
// Shared constants, types and helpers for the debug comparator registers
package dbg_cmp_pkg;
   // Widths
   localparam int REG_W = 8;
   localparam int CPU_AW = 18;
   localparam int CPU_DW = 16;
   localparam int NUM_CMP = 3;
   localparam int HIGH_W = 2;
   // Offsets of the register map
   localparam logic [7:0] OFF_CTRL_ONE = 8'h20;
   localparam logic [7:0] OFF_CTRL_A = 8'h21;
   localparam logic [7:0] OFF_MATCH_STAT = 8'h22;
   localparam logic [7:0] OFF_WIN_BASE = 8'h28;
   localparam logic [7:0] OFF_ADDR_HIGH = 8'h29;
   localparam logic [7:0] OFF_ADDR_MID = 8'h2a;
   localparam logic [7:0] OFF_ADDR_LOW = 8'h2b;
   localparam logic [7:0] OFF_DATA_HIGH = 8'h2c;
   localparam logic [7:0] OFF_DATA_LOW = 8'h2d;
   localparam logic [7:0] OFF_DMASK_HIGH = 8'h2e;
   localparam logic [7:0] OFF_DMASK_LOW = 8'h2f;
   // Field positions
   localparam int ARM_BIT = 7;
   localparam int TAG_BIT = 0;
   // Reset values
   localparam logic [REG_W-1:0] RST_BYTE = 8'h00;
   localparam logic [CPU_AW-1:0] RST_ADDR = 18'h00000;
   localparam logic [CPU_DW-1:0] RST_WORD = 16'h0000;
   // Comparator view select encoding
   typedef enum logic [1:0] {
      VIEW_A = 2'h0,
      VIEW_B = 2'h1,
      VIEW_C = 2'h2,
      VIEW_NONE = 2'h3
   } view_t;
   // Address compare registers of one comparator
   typedef logic [CPU_AW-1:0] cmp_addr_t;

   // True for an offset inside the shared 8-byte window
   function automatic logic in_window(input logic [7:0] a);
      return (a >= OFF_WIN_BASE) && (a <= OFF_DMASK_LOW);
   endfunction

   // True for an offset of the data compare or mask registers
   function automatic logic is_data_reg(input logic [7:0] a);
      return (a >= OFF_DATA_HIGH) && (a <= OFF_DMASK_LOW);
   endfunction
endpackage

/* File: logic/cmp_cfg_if.sv */
// Signals between register front end, register bank and matcher
`timescale 1ns/1ps
interface cmp_cfg_if;
   import dbg_cmp_pkg::*;
   logic wr_en;
   logic [7:0] wr_off;
   view_t wr_view;
   logic [REG_W-1:0] wr_data;
   cmp_addr_t [NUM_CMP-1:0] cmp_addr;
   logic [CPU_DW-1:0] data_val;
   logic [CPU_DW-1:0] data_mask;
   logic tag_a;
   logic [CPU_AW-1:0] cpu_addr;
   logic [CPU_DW-1:0] cpu_data;
   logic cpu_valid;
   logic [NUM_CMP-1:0] match;
   modport front (output wr_en, wr_off, wr_view, wr_data, tag_a, cpu_addr, cpu_data,
      cpu_valid, input cmp_addr, data_val, data_mask, match);
   modport bank (input wr_en, wr_off, wr_view, wr_data,
      output cmp_addr, data_val, data_mask);
   modport matcher (input cmp_addr, data_val, data_mask, tag_a, cpu_addr, cpu_data,
      cpu_valid, output match);
endinterface

/* File: logic/cmp_bank.sv */
// Storage of the address, data and mask compare values
`timescale 1ns/1ps
module cmp_bank
   import dbg_cmp_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   cmp_cfg_if.bank cb
);
   typedef struct packed {
      cmp_addr_t [NUM_CMP-1:0] addr;
      logic [CPU_DW-1:0] dval;
      logic [CPU_DW-1:0] dmask;
   } bank_st_t;

   bank_st_t st_r;
   bank_st_t st_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Byte writes into the selected comparator, gated by the front end
   always_comb
   begin
      st_nxt = st_r;
      if (cb.wr_en)
      begin
         unique case (cb.wr_off)
            OFF_ADDR_HIGH: st_nxt.addr[cb.wr_view][CPU_AW-1:16] = cb.wr_data[HIGH_W-1:0];
            OFF_ADDR_MID: st_nxt.addr[cb.wr_view][15:8] = cb.wr_data;
            OFF_ADDR_LOW: st_nxt.addr[cb.wr_view][7:0] = cb.wr_data;
            OFF_DATA_HIGH: st_nxt.dval[15:8] = cb.wr_data;
            OFF_DATA_LOW: st_nxt.dval[7:0] = cb.wr_data;
            OFF_DMASK_HIGH: st_nxt.dmask[15:8] = cb.wr_data;
            OFF_DMASK_LOW: st_nxt.dmask[7:0] = cb.wr_data;
            default: ;
         endcase
      end
   end

   // State register, cleared by reset
   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_r <= '{addr: {NUM_CMP{RST_ADDR}}, dval: RST_WORD, dmask: RST_WORD};
      else
         st_r <= st_nxt;
   end

   assign cb.cmp_addr = st_r.addr;
   assign cb.data_val = st_r.dval;
   assign cb.data_mask = st_r.dmask;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_high_two_bits : assert property (@(posedge clk) disable iff (!rstn)
      cb.wr_en && cb.wr_off == OFF_ADDR_HIGH && cb.wr_view == VIEW_B
      |=> cb.cmp_addr[1][CPU_AW-1:16] == $past(cb.wr_data[HIGH_W-1:0]))
      else $error("address high bits not stored");
endmodule

/* File: logic/cmp_match.sv */
// Address and masked data comparison against the CPU buses
`timescale 1ns/1ps
module cmp_match
   import dbg_cmp_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   cmp_cfg_if.matcher cb
);
   typedef struct packed {
      logic [NUM_CMP-1:0] match;
   } match_st_t;

   match_st_t st_r;
   match_st_t st_nxt;
   logic data_ok;

   // Exact equivalence of the address bus with one comparator
   function automatic logic addr_hit(input cmp_addr_t a, input cmp_addr_t v);
      return a == v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Per-comparator match, data qualifies comparator A only
   always_comb
   begin
      st_nxt = st_r;
      data_ok = cb.tag_a;
      if (((cb.cpu_data ^ cb.data_val) & cb.data_mask) == RST_WORD)
         data_ok = 1'b1;
      for (int i = 0; i < NUM_CMP; i++)
         st_nxt.match[i] = cb.cpu_valid && addr_hit(cb.cpu_addr, cb.cmp_addr[i]);
      st_nxt.match[0] = st_nxt.match[0] && data_ok;
   end

   // Match register
   always_ff @(posedge clk)
   begin
      if (!rstn)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign cb.match = st_r.match;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_tag_skips_data : assert property (@(posedge clk) disable iff (!rstn)
      cb.cpu_valid && cb.tag_a && cb.cpu_addr == cb.cmp_addr[0] |=> cb.match[0])
      else $error("data checked while opcode marking set");
   a_mask_clear_any : assert property (@(posedge clk) disable iff (!rstn)
      cb.cpu_valid && cb.data_mask == RST_WORD && cb.cpu_addr == cb.cmp_addr[0]
      |=> cb.match[0])
      else $error("unmasked data blocked a match");
   a_data_differs : assert property (@(posedge clk) disable iff (!rstn)
      cb.cpu_valid && !cb.tag_a && ((cb.cpu_data ^ cb.data_val) & cb.data_mask) != RST_WORD
      |=> !cb.match[0])
      else $error("masked data mismatch still matched");
   a_addr_miss : assert property (@(posedge clk) disable iff (!rstn)
      cb.cpu_addr != cb.cmp_addr[2] |=> !cb.match[2])
      else $error("comparator C matched a different address");
endmodule

/* File: logic/dbg_cmp_regs.sv */
// Debug comparator match registers: register front end and top level
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
module dbg_cmp_regs
   import dbg_cmp_pkg::*;
(
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [7:0] ADDR,
   input wire logic [REG_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [REG_W-1:0] RDATA,
   input wire logic [CPU_AW-1:0] CPU_ADDR,
   input wire logic [CPU_DW-1:0] CPU_DATA,
   input wire logic CPU_VALID,
   output logic MATCH_A,
   output logic MATCH_B,
   output logic MATCH_C,
   output logic ARMED
);
   typedef struct packed {
      logic arm;
      view_t view;
      logic tag_a;
      logic [REG_W-1:0] rdata;
   } front_st_t;

   front_st_t st_r;
   front_st_t st_nxt;
   cmp_addr_t vis;
   logic [REG_W-1:0] rd_val;
   logic win_wr_ok;

   cmp_cfg_if cb ();

   ////////////////////////////////////////////////////////////////////////////
   // Submodules
   cmp_bank u_bank (
      .clk(CLK),
      .rstn(RSTN),
      .cb(cb.bank)
   );

   cmp_match u_match (
      .clk(CLK),
      .rstn(RSTN),
      .cb(cb.matcher)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Comparator visible through the window, nothing for the hidden view
   always_comb
   begin
      unique case (st_r.view)
         VIEW_A: vis = cb.cmp_addr[0];
         VIEW_B: vis = cb.cmp_addr[1];
         VIEW_C: vis = cb.cmp_addr[2];
         VIEW_NONE: vis = RST_ADDR;
      endcase
   end

   // Window write permission by register group, view and arming
   always_comb
   begin
      win_wr_ok = 1'b0;
      if (!st_r.arm && in_window(ADDR) && ADDR != OFF_WIN_BASE)
      begin
         if (is_data_reg(ADDR))
            win_wr_ok = (st_r.view == VIEW_A);
         else
            win_wr_ok = (st_r.view != VIEW_NONE);
      end
   end

   // Write path into the bank and bus snoop path into the matcher
   assign cb.wr_en = WR && win_wr_ok;
   assign cb.wr_off = ADDR;
   assign cb.wr_view = st_r.view;
   assign cb.wr_data = WDATA;
   assign cb.tag_a = st_r.tag_a;
   assign cb.cpu_addr = CPU_ADDR;
   assign cb.cpu_data = CPU_DATA;
   assign cb.cpu_valid = CPU_VALID;

   ////////////////////////////////////////////////////////////////////////////
   // Read multiplexer, unmapped and hidden offsets read zero
   always_comb
   begin
      rd_val = RST_BYTE;
      unique case (ADDR)
         OFF_CTRL_ONE:
         begin
            rd_val[ARM_BIT] = st_r.arm;
            rd_val[1:0] = st_r.view;
         end
         OFF_CTRL_A: rd_val[TAG_BIT] = st_r.tag_a;
         OFF_MATCH_STAT: rd_val[NUM_CMP-1:0] = cb.match;
         OFF_ADDR_HIGH: rd_val[HIGH_W-1:0] = vis[CPU_AW-1:16];
         OFF_ADDR_MID: rd_val = vis[15:8];
         OFF_ADDR_LOW: rd_val = vis[7:0];
         OFF_DATA_HIGH:
            if (st_r.view == VIEW_A)
               rd_val = cb.data_val[15:8];
         OFF_DATA_LOW:
            if (st_r.view == VIEW_A)
               rd_val = cb.data_val[7:0];
         OFF_DMASK_HIGH:
            if (st_r.view == VIEW_A)
               rd_val = cb.data_mask[15:8];
         OFF_DMASK_LOW:
            if (st_r.view == VIEW_A)
               rd_val = cb.data_mask[7:0];
         default: rd_val = RST_BYTE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register writes and read data capture
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.rdata = RST_BYTE;
      if (WR)
      begin
         unique case (ADDR)
            OFF_CTRL_ONE:
            begin
               st_nxt.arm = WDATA[ARM_BIT];
               st_nxt.view = view_t'(WDATA[1:0]);
            end
            OFF_CTRL_A:
               if (!st_r.arm)
                  st_nxt.tag_a = WDATA[TAG_BIT];
            default: ;
         endcase
      end
      if (RD)
         st_nxt.rdata = rd_val;
   end

   // State register, synchronous reset to zero
   always_ff @(posedge CLK)
   begin
      if (!RSTN)
         st_r <= '{arm: 1'b0, view: VIEW_A, tag_a: 1'b0, rdata: RST_BYTE};
      else
         st_r <= st_nxt;
   end

   // Outputs, each straight from a flip-flop
   assign RDATA = st_r.rdata;
   assign ARMED = st_r.arm;
   assign MATCH_A = cb.match[0];
   assign MATCH_B = cb.match[1];
   assign MATCH_C = cb.match[2];

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking dc @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   a_armed_addr_hold : assert property (
      st_r.arm && WR && ADDR == OFF_ADDR_LOW |=> $stable(cb.cmp_addr))
      else $error("address register changed while armed");

   a_view_b_write : assert property (
      !st_r.arm && WR && ADDR == OFF_ADDR_LOW && st_r.view == VIEW_B
      |=> cb.cmp_addr[1][7:0] == $past(WDATA) && $stable(cb.cmp_addr[0]))
      else $error("write missed comparator B low register");

   a_hidden_reads_zero : assert property (
      RD && st_r.view == VIEW_NONE && in_window(ADDR) |=> RDATA == RST_BYTE)
      else $error("hidden view returned data");

   a_hidden_no_store : assert property (
      WR && st_r.view == VIEW_NONE && in_window(ADDR)
      |=> $stable(cb.cmp_addr) && $stable(cb.data_val) && $stable(cb.data_mask))
      else $error("hidden view write changed a comparator");

   a_data_view_read : assert property (
      RD && ADDR == OFF_DATA_HIGH && st_r.view != VIEW_A |=> RDATA == RST_BYTE)
      else $error("data register seen outside view A");

   a_mask_write_gate : assert property (
      WR && ADDR == OFF_DMASK_LOW && (st_r.arm || st_r.view != VIEW_A)
      |=> $stable(cb.data_mask))
      else $error("mask changed without permission");

   a_mask_low_store : assert property (
      WR && ADDR == OFF_DMASK_LOW && !st_r.arm && st_r.view == VIEW_A
      |=> cb.data_mask[7:0] == $past(WDATA))
      else $error("low mask not stored");

   a_armed_read_mid : assert property (
      RD && ADDR == OFF_ADDR_MID && st_r.arm && st_r.view == VIEW_C
      |=> RDATA == $past(cb.cmp_addr[2][15:8]))
      else $error("armed read of mid register wrong");

   a_high_read_narrow : assert property (
      RD && ADDR == OFF_ADDR_HIGH |=> RDATA[REG_W-1:HIGH_W] == 6'h00)
      else $error("unused high bits read nonzero");

   a_data_high_store : assert property (
      WR && ADDR == OFF_DATA_HIGH && !st_r.arm && st_r.view == VIEW_A
      ##1 !WR [*2] |-> cb.data_val[15:8] == $past(WDATA, 2))
      else $error("data high not held");

   a_data_low_read : assert property (
      RD && ADDR == OFF_DATA_LOW && st_r.view == VIEW_A
      |=> RDATA == $past(cb.data_val[7:0]))
      else $error("data low read wrong");

   a_rdata_one_cycle : assert property (
      !RD |=> RDATA == RST_BYTE)
      else $error("read data outside its cycle");

   // Window and control register permissions, stores and reads per register
   a_armed_mid_hold : assert property (
      st_r.arm && WR && ADDR == OFF_ADDR_MID |=> $stable(cb.cmp_addr))
      else $error("mid register changed while armed");

   a_armed_high_hold : assert property (
      st_r.arm && WR && ADDR == OFF_ADDR_HIGH |=> $stable(cb.cmp_addr))
      else $error("high register changed while armed");

   a_armed_data_hold : assert property (
      st_r.arm && WR && is_data_reg(ADDR) |=> $stable(cb.data_val) && $stable(cb.data_mask))
      else $error("data register changed while armed");

   a_view_a_low : assert property (
      !st_r.arm && WR && ADDR == OFF_ADDR_LOW && st_r.view == VIEW_A
      |=> cb.cmp_addr[0][7:0] == $past(WDATA))
      else $error("write missed comparator A low register");

   a_view_c_mid : assert property (
      !st_r.arm && WR && ADDR == OFF_ADDR_MID && st_r.view == VIEW_C
      |=> cb.cmp_addr[2][15:8] == $past(WDATA))
      else $error("write missed comparator C mid register");

   a_view_a_high : assert property (
      !st_r.arm && WR && ADDR == OFF_ADDR_HIGH && st_r.view == VIEW_A
      |=> cb.cmp_addr[0][CPU_AW-1:16] == $past(WDATA[HIGH_W-1:0]))
      else $error("write missed comparator A high register");

   a_data_low_store : assert property (
      WR && ADDR == OFF_DATA_LOW && !st_r.arm && st_r.view == VIEW_A
      |=> cb.data_val[7:0] == $past(WDATA))
      else $error("data low not stored");

   a_mask_high_store : assert property (
      WR && ADDR == OFF_DMASK_HIGH && !st_r.arm && st_r.view == VIEW_A
      |=> cb.data_mask[15:8] == $past(WDATA))
      else $error("high mask not stored");

   a_data_view_write : assert property (
      WR && is_data_reg(ADDR) && st_r.view != VIEW_A
      |=> $stable(cb.data_val) && $stable(cb.data_mask))
      else $error("data register written outside view A");

   a_mask_low_read : assert property (
      RD && ADDR == OFF_DMASK_LOW && st_r.view == VIEW_A
      |=> RDATA == $past(cb.data_mask[7:0]))
      else $error("low mask read wrong");

   a_mask_high_read : assert property (
      RD && ADDR == OFF_DMASK_HIGH && st_r.view == VIEW_A
      |=> RDATA == $past(cb.data_mask[15:8]))
      else $error("high mask read wrong");

   a_data_high_read : assert property (
      RD && ADDR == OFF_DATA_HIGH && st_r.view == VIEW_A
      |=> RDATA == $past(cb.data_val[15:8]))
      else $error("data high read wrong");

   a_low_read_b : assert property (
      RD && ADDR == OFF_ADDR_LOW && st_r.view == VIEW_B
      |=> RDATA == $past(cb.cmp_addr[1][7:0]))
      else $error("comparator B low read wrong");

   a_base_reads_zero : assert property (
      RD && ADDR == OFF_WIN_BASE |=> RDATA == RST_BYTE)
      else $error("window base offset returned data");

   a_base_no_store : assert property (
      WR && ADDR == OFF_WIN_BASE
      |=> $stable(cb.cmp_addr) && $stable(cb.data_val) && $stable(cb.data_mask))
      else $error("window base write changed a comparator");

   a_view_follows : assert property (
      WR && ADDR == OFF_CTRL_ONE |=> st_r.view == $past(WDATA[1:0]))
      else $error("view select not taken");

   a_arm_follows : assert property (
      WR && ADDR == OFF_CTRL_ONE |=> ARMED == $past(WDATA[ARM_BIT]))
      else $error("arm bit not taken");

   a_tag_armed_hold : assert property (
      st_r.arm && WR && ADDR == OFF_CTRL_A |=> $stable(st_r.tag_a))
      else $error("opcode marking changed while armed");

   a_tag_store : assert property (
      !st_r.arm && WR && ADDR == OFF_CTRL_A |=> st_r.tag_a == $past(WDATA[TAG_BIT]))
      else $error("opcode marking not stored");

   c_armed_write : cover property (st_r.arm && WR && in_window(ADDR));
   c_view_c_read : cover property (RD && st_r.view == VIEW_C && ADDR == OFF_ADDR_LOW);
   c_match_a : cover property (MATCH_A && !st_r.tag_a && cb.data_mask != RST_WORD);
   c_back_to_back : cover property (WR ##1 RD);
endmodule

/* File: sim/cpu_bus_model.sv */
// CPU system bus model driving address, data and cycle qualifier
`timescale 1ns/1ps
module cpu_bus_model
   import dbg_cmp_pkg::*;
(
   input wire logic clk,
   output logic [CPU_AW-1:0] cpu_addr,
   output logic [CPU_DW-1:0] cpu_data,
   output logic cpu_valid
);
   // Quiet bus at time zero
   initial
   begin
      cpu_addr = 18'h3ffff;
      cpu_data = 16'hffff;
      cpu_valid = 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // One bus cycle, qualified for one clock; afterwards the released bus shows
   // the inverse of the last value so a stale copy can never match by accident
   task automatic bus_cycle(input logic [CPU_AW-1:0] a, input logic [CPU_DW-1:0] d);
      @(posedge clk);
      cpu_valid <= 1'b1;
      cpu_addr <= a;
      cpu_data <= d;
      @(posedge clk);
      cpu_valid <= 1'b0;
      cpu_addr <= ~a;
      cpu_data <= ~d;
   endtask
endmodule

/* File: sim/dbg_cmp_regs_tb.sv */
// Self-checking bench for the debug comparator match registers
`timescale 1ns/1ps
module dbg_cmp_regs_tb;
   import dbg_cmp_pkg::*;
   logic CLK = 1'b0;
   logic RSTN = 1'b0;
   logic [7:0] ADDR = 8'h00;
   logic [REG_W-1:0] WDATA = 8'h00;
   logic WR = 1'b0;
   logic RD = 1'b0;
   logic [REG_W-1:0] RDATA;
   logic [CPU_AW-1:0] CPU_ADDR;
   logic [CPU_DW-1:0] CPU_DATA;
   logic CPU_VALID;
   logic MATCH_A, MATCH_B, MATCH_C, ARMED;
   int err_count = 0;
   int checks = 0;
   int cycles = 0;
   // Address values of comparators A, B, C as high, mid, low bytes
   logic [7:0] av [3][3] = '{'{8'h02, 8'ha5, 8'hc3}, '{8'h01, 8'h5a, 8'h3c},
      '{8'h03, 8'hf0, 8'h0f}};

   // Clock, 50 MHz
   always #10 CLK = ~CLK;

   dbg_cmp_regs u_dbg_cmp_regs (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .CPU_ADDR(CPU_ADDR), .CPU_DATA(CPU_DATA),
      .CPU_VALID(CPU_VALID), .MATCH_A(MATCH_A), .MATCH_B(MATCH_B), .MATCH_C(MATCH_C),
      .ARMED(ARMED));
   cpu_bus_model u_cpu_bus_model (.clk(CLK), .cpu_addr(CPU_ADDR), .cpu_data(CPU_DATA),
      .cpu_valid(CPU_VALID));

   ////////////////////////////////////////////////////////////////////////////////
   // Compare, verdict and register bus tasks
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic chk_match(input logic [2:0] exp);
      checks++;
      if ({MATCH_C, MATCH_B, MATCH_A} !== exp)
      begin
         err_count++;
         $display("wrong value match expected %b seen %b", exp, {MATCH_C, MATCH_B, MATCH_A});
      end
   endtask

   task automatic print_verdict();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge CLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge CLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      chk($sformatf("reg %h", a), exp, RDATA);
   endtask

   // Bus cycle from the CPU model, match flags judged one cycle later
   task automatic bus(input logic [17:0] a, input logic [15:0] d, input logic [2:0] exp);
      u_cpu_bus_model.bus_cycle(a, d);
      @(negedge CLK);
      chk_match(exp);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      for (int o = 8'h29; o <= 8'h2f; o++)
         rd(o[7:0], 8'h00);
      chk("armed", 8'h00, {7'h0, ARMED});
   endtask

   // Each view reaches its own comparator, view 11 reaches none
   task automatic t_views();
      for (int v = 0; v < 3; v++)
      begin
         wr(8'h20, v[7:0]);
         for (int i = 0; i < 3; i++)
            wr(8'h29 + i[7:0], av[v][i] | (i == 0 ? 8'hfc : 8'h00));
      end
      wr(8'h20, 8'h03);
      wr(8'h2b, 8'h77);
      rd(8'h2b, 8'h00);
      for (int v = 0; v < 3; v++)
      begin
         wr(8'h20, v[7:0]);
         for (int i = 0; i < 3; i++)
            rd(8'h29 + i[7:0], av[v][i]);
      end
      wr(8'h2c, 8'hff);
      rd(8'h2c, 8'h00);
      wr(8'h20, 8'h00);
      rd(8'h2c, 8'h00);
      wr(8'h28, 8'hff);
      rd(8'h28, 8'h00);
   endtask

   // Address and masked data comparison
   task automatic t_match();
      bus(18'h2a5c3, 16'h5555, 3'b001);
      wr(8'h2c, 8'h12);
      rd(8'h2c, 8'h12);
      wr(8'h2d, 8'h34);
      wr(8'h2e, 8'hff);
      rd(8'h2d, 8'h34);
      rd(8'h2e, 8'hff);
      bus(18'h2a5c3, 16'h12ee, 3'b001);
      bus(18'h2a5c3, 16'h13ee, 3'b000);
      bus(18'h15a3c, 16'h0000, 3'b010);
      // Status read lands in the one cycle in which comparator B's flag stands
      fork
         u_cpu_bus_model.bus_cycle(18'h15a3c, 16'h0000);
         begin
            @(posedge CLK);
            rd(8'h22, 8'h02);
         end
      join
      bus(18'h3f00f, 16'hffff, 3'b100);
      bus(18'h3a5c3, 16'h12ee, 3'b000);
      wr(8'h2f, 8'h0f);
      rd(8'h2f, 8'h0f);
      bus(18'h2a5c3, 16'h12e4, 3'b001);
      bus(18'h2a5c3, 16'h12e5, 3'b000);
      wr(8'h21, 8'h01);
      rd(8'h21, 8'h01);
      bus(18'h2a5c3, 16'h13e5, 3'b001);
      wr(8'h21, 8'h00);
   endtask

   // Armed module refuses window and opcode marking writes but keeps reads and view select writes open
   task automatic t_armed();
      wr(8'h20, 8'h80);
      wr(8'h2b, 8'h55);
      wr(8'h2c, 8'haa);
      wr(8'h2f, 8'hff);
      wr(8'h29, 8'hff);
      wr(8'h2a, 8'hff);
      wr(8'h21, 8'h01);
      chk("armed", 8'h01, {7'h0, ARMED});
      rd(8'h2b, 8'hc3);
      rd(8'h29, 8'h02);
      rd(8'h2a, 8'ha5);
      rd(8'h2c, 8'h12);
      rd(8'h2f, 8'h0f);
      rd(8'h21, 8'h00);
      wr(8'h20, 8'h81);
      rd(8'h20, 8'h81);
      rd(8'h2b, 8'h3c);
      wr(8'h20, 8'h82);
      rd(8'h2a, 8'hf0);
      wr(8'h20, 8'h00);
      wr(8'h2b, 8'h55);
      rd(8'h2b, 8'h55);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Hang guard
   always @(posedge CLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         print_verdict();
      end
   end

   // Main sequence
   initial
   begin
      repeat (5) @(posedge CLK);
      RSTN <= 1'b1;
      t_reset();
      t_views();
      t_match();
      t_armed();
      print_verdict();
   end
endmodule
